// *** sdl_top.sv ***
// Serial master port with Wishbone registers for loading a quad DAC
`include "sdl_consts.svh"
`default_nettype none
// Behaviour
// [RULE_01] Done bit 7; status read, data access clears
// [RULE_02] Data write while busy sets collision bit 6
// [RULE_03] Master with select low sets fault bit 4
// [RULE_04] Control bits layout; reset 0x04, rate undefined
// [RULE_05] Master data write starts full-duplex byte transfer
// [RULE_06] Controller is always master; DAC is slave
// [RULE_07] Three-wire format behaves as polarity 0, phase 0
// [RULE_08] Chip select from general-purpose output, not select
// [RULE_09] High byte of DAC word goes first
// [RULE_10] Poll status for done before next byte
// [RULE_11] Read data after second byte, raise select
// [RULE_12] Interrupt enable raises request on done or fault
// [RULE_13] Polarity sets serial clock idle level
// [RULE_14] Rate bits divide by 2, 4, 16, 32
// [RULE_15] Port enable hands pins to serial function
// [RULE_16] Typical setup: enable, master, mode 0, rate
// [RULE_17] Eight bits, MSB first, sixteen clocks per word
module sdl_top (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   output logic               irq_o,
   output logic               sck_o,
   output logic               sck_oe_o,
   output logic               mosi_o,
   output logic               mosi_oe_o,
   input  wire logic          miso_i,
   input  wire logic          sel_n_i
);
   import sdl_pkg::*;

   sdl_xfer_if  xf ();

   logic [1:0]  miso_s_q, ss_s_q;
   logic        ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic [7:0]  ctrl_q, ctrl_d;
   logic [7:0]  tx_q, tx_d, rx_q, rx_d;
   logic        done_q, done_d, write_collision_flag_q, write_collision_flag_d, mode_fault_flag_q, mode_fault_flag_d;
   logic        arm_done_q, arm_done_d, arm_write_collision_flag_q, arm_write_collision_flag_d;
   logic        arm_mode_fault_flag_q, arm_mode_fault_flag_d;
   logic        start_q, start_d;
   logic [2:0]  ev_q, ev_d, en_q, en_d, ev_set;
   logic        acc, wr, rd, dat_acc, fault, sck_int, mosi_int, pins_on;
   logic [5:0]  idx;
   logic [7:0]  stat;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         miso_s_q <= 2'h0;
         ss_s_q   <= 2'h3;
      end else begin
         miso_s_q <= {miso_s_q[0], miso_i};
         ss_s_q   <= {ss_s_q[0], sel_n_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus decode; writes and read side effects land on the ack edge
   assign idx     = wb_adr_i[7:2];
   assign acc     = wb_cyc_i & wb_stb_i & ack_q;
   assign wr      = acc & wb_we_i & wb_sel_i[0];
   assign rd      = acc & ~wb_we_i;
   assign dat_acc = (rd | wr) & (idx == `SDL_IDX_DATA);
   assign fault   = ctrl_q[`SDL_CTRL_SPE] & ctrl_q[`SDL_CTRL_MASTER_SELECT]
                    & ~ss_s_q[1]; // see [RULE_03]

   always_comb begin
      stat = 8'h00;
      stat[`SDL_STAT_DONE] = done_q;
      stat[`SDL_STAT_WRITE_COLLISION_FLAG] = write_collision_flag_q;
      stat[`SDL_STAT_MODE_FAULT_FLAG] = mode_fault_flag_q;
   end

   always_comb begin
      ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
      dat_d = 32'h0000_0000;
      if (ack_d & ~wb_we_i) begin
         unique case (idx)
            `SDL_IDX_CTRL:    dat_d[7:0] = ctrl_q;
            `SDL_IDX_STAT:    dat_d[7:0] = stat;
            `SDL_IDX_DATA:    dat_d[7:0] = rx_q;
            `SDL_IDX_EV_STAT: dat_d[2:0] = ev_q;
            `SDL_IDX_EV_EN:   dat_d[2:0] = en_q;
            default:          dat_d      = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers and flags; a hardware set beats a same-cycle clear
   always_comb begin
      ctrl_d     = ctrl_q;
      tx_d       = tx_q;
      rx_d       = rx_q;
      start_d    = 1'b0;
      done_d     = done_q;
      write_collision_flag_d     = write_collision_flag_q;
      mode_fault_flag_d     = mode_fault_flag_q;
      arm_done_d = arm_done_q;
      arm_write_collision_flag_d = arm_write_collision_flag_q;
      arm_mode_fault_flag_d = arm_mode_fault_flag_q;
      en_d       = en_q;
      ev_set     = 3'h0;
      if (rd && idx == `SDL_IDX_STAT) begin
         arm_done_d = done_q;
         arm_write_collision_flag_d = write_collision_flag_q;
         arm_mode_fault_flag_d = mode_fault_flag_q;
      end
      if (wr && idx == `SDL_IDX_CTRL) begin
         ctrl_d = wb_dat_i[7:0]; // see [RULE_04]
         if (arm_mode_fault_flag_q)
            mode_fault_flag_d = 1'b0; // see [RULE_03]
         arm_mode_fault_flag_d = 1'b0;
      end
      if (dat_acc) begin
         if (arm_done_q)
            done_d = 1'b0; // see [RULE_01]
         if (arm_write_collision_flag_q)
            write_collision_flag_d = 1'b0; // see [RULE_02]
         arm_done_d = 1'b0;
         arm_write_collision_flag_d = 1'b0;
      end
      if (wr && idx == `SDL_IDX_DATA) begin
         if (xf.busy || start_q) begin
            // Colliding byte is dropped, the running transfer is kept
            write_collision_flag_d    = 1'b1; // see [RULE_02]
            ev_set[`SDL_EV_WRITE_COLLISION_FLAG] = 1'b1;
         end else begin
            tx_d = wb_dat_i[7:0];
            start_d = ctrl_q[`SDL_CTRL_MASTER_SELECT]
                      & ctrl_q[`SDL_CTRL_SPE]; // see [RULE_05]
         end
      end
      if (wr && idx == `SDL_IDX_EV_EN)
         en_d = wb_dat_i[2:0];
      if (xf.done) begin
         rx_d   = xf.rx_data;
         done_d = 1'b1; // see [RULE_01]
         ev_set[`SDL_EV_DONE] = 1'b1;
      end
      if (fault) begin
         mode_fault_flag_d = 1'b1; // see [RULE_03]
         ev_set[`SDL_EV_MODE_FAULT_FLAG] = 1'b1;
      end
      ev_d = ev_q;
      if (wr && idx == `SDL_IDX_EV_CLR)
         ev_d = ev_q & ~wb_dat_i[2:0];
      ev_d = ev_d | ev_set;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q      <= 1'b0;
         dat_q      <= 32'h0000_0000;
         ctrl_q     <= `SDL_CTRL_RESET; // see [RULE_04]
         tx_q       <= 8'h00;
         rx_q       <= 8'h00;
         start_q    <= 1'b0;
         done_q     <= 1'b0;
         write_collision_flag_q     <= 1'b0;
         mode_fault_flag_q     <= 1'b0;
         arm_done_q <= 1'b0;
         arm_write_collision_flag_q <= 1'b0;
         arm_mode_fault_flag_q <= 1'b0;
         ev_q       <= 3'h0;
         en_q       <= 3'h0;
      end else begin
         ack_q      <= ack_d;
         dat_q      <= dat_d;
         ctrl_q     <= ctrl_d;
         tx_q       <= tx_d;
         rx_q       <= rx_d;
         start_q    <= start_d;
         done_q     <= done_d;
         write_collision_flag_q     <= write_collision_flag_d;
         mode_fault_flag_q     <= mode_fault_flag_d;
         arm_done_q <= arm_done_d;
         arm_write_collision_flag_q <= arm_write_collision_flag_d;
         arm_mode_fault_flag_q <= arm_mode_fault_flag_d;
         ev_q       <= ev_d;
         en_q       <= en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shift engine
   assign xf.start   = start_q;
   assign xf.tx_data = tx_q;
   assign xf.clock_polarity    = ctrl_q[`SDL_CTRL_CLOCK_POLARITY];
   assign xf.clock_phase    = ctrl_q[`SDL_CTRL_CLOCK_PHASE];
   assign xf.rate    = sdl_rate_t'(ctrl_q[1:0]); // see [RULE_14]

   sdl_shifter u_shift (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .x      (xf),
      .miso_i (miso_s_q[1]),
      .sck_o  (sck_int),
      .mosi_o (mosi_int)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pins: open-drain mode only ever pulls low
   assign pins_on   = ctrl_q[`SDL_CTRL_SPE]
                      & ctrl_q[`SDL_CTRL_MASTER_SELECT]; // see [RULE_15]
   assign sck_o     = sck_int & ~ctrl_q[`SDL_CTRL_ODS];
   assign mosi_o    = mosi_int & ~ctrl_q[`SDL_CTRL_ODS];
   assign sck_oe_o  = pins_on & (~ctrl_q[`SDL_CTRL_ODS] | ~sck_int);
   assign mosi_oe_o = pins_on & (~ctrl_q[`SDL_CTRL_ODS] | ~mosi_int);

   assign wb_ack_o  = ack_q;
   assign wb_dat_o  = dat_q;
   assign irq_o     = (ctrl_q[`SDL_CTRL_IEN] & (done_q | mode_fault_flag_q))
                      | (|(ev_q & en_q)); // see [RULE_12]
endmodule
`default_nettype wire

// *** sdl_consts.svh ***
// Register map, field positions, reset values and timing for the DAC loader
`ifndef SDL_CONSTS_SVH
`define SDL_CONSTS_SVH

`define SDL_IDX_CTRL      6'h28
`define SDL_IDX_STAT      6'h29
`define SDL_IDX_DATA      6'h2A
`define SDL_IDX_EV_STAT   6'h2C
`define SDL_IDX_EV_CLR    6'h2D
`define SDL_IDX_EV_EN     6'h2E

`define SDL_CTRL_IEN      7
`define SDL_CTRL_SPE      6
`define SDL_CTRL_ODS      5
`define SDL_CTRL_MASTER_SELECT     4
`define SDL_CTRL_CLOCK_POLARITY     3
`define SDL_CTRL_CLOCK_PHASE     2
`define SDL_CTRL_RESET    8'h04

`define SDL_STAT_DONE     7
`define SDL_STAT_WRITE_COLLISION_FLAG     6
`define SDL_STAT_MODE_FAULT_FLAG     4

`define SDL_EV_DONE       0
`define SDL_EV_WRITE_COLLISION_FLAG       1
`define SDL_EV_MODE_FAULT_FLAG       2

`define SDL_HALF_DIV2     5'h01
`define SDL_HALF_DIV4     5'h02
`define SDL_HALF_DIV16    5'h08
`define SDL_HALF_DIV32    5'h10
`define SDL_EDGES         5'h10

`endif

// *** sdl_pkg.sv ***
// Types shared by the DAC loader modules
`default_nettype none
package sdl_pkg;
   typedef enum logic [1:0] {
      SDL_RATE_DIV2,
      SDL_RATE_DIV4,
      SDL_RATE_DIV16,
      SDL_RATE_DIV32
   } sdl_rate_t;
   typedef enum {
      SDL_IDLE,
      SDL_SHIFT,
      SDL_FINISH
   } sdl_state_t;
endpackage
`default_nettype wire

// *** sdl_xfer_if.sv ***
// Transfer request and result between register file and shift engine
`default_nettype none
interface sdl_xfer_if;
   logic                    start;
   logic [7:0]              tx_data;
   logic                    clock_polarity;
   logic                    clock_phase;
   sdl_pkg::sdl_rate_t      rate;
   logic                    busy;
   logic                    done;
   logic [7:0]              rx_data;
   modport ctrl (output start, tx_data, clock_polarity, clock_phase, rate,
                 input busy, done, rx_data);
   modport eng  (input start, tx_data, clock_polarity, clock_phase, rate,
                 output busy, done, rx_data);
endinterface
`default_nettype wire

// *** sdl_shifter.sv ***
// Byte shift engine: serial clock generation, transmit and receive
`include "sdl_consts.svh"
`default_nettype none
module sdl_shifter (
   input  wire logic    clk_i,
   input  wire logic    rst_i,
   sdl_xfer_if.eng      x,
   input  wire logic    miso_i,
   output logic         sck_o,
   output logic         mosi_o
);
   import sdl_pkg::*;

   sdl_state_t  state_q, state_d;
   logic [4:0]  div_q, div_d, half;
   logic [4:0]  edge_q, edge_d;
   logic [7:0]  sreg_q, sreg_d;
   logic        rxb_q, rxb_d;
   logic        ph_q, ph_d;
   logic        done_q, done_d;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      unique case (x.rate)
         SDL_RATE_DIV2:  half = `SDL_HALF_DIV2; // see [RULE_14]
         SDL_RATE_DIV4:  half = `SDL_HALF_DIV4;
         SDL_RATE_DIV16: half = `SDL_HALF_DIV16;
         SDL_RATE_DIV32: half = `SDL_HALF_DIV32;
      endcase
   end

   always_comb begin
      state_d = state_q;
      div_d   = div_q;
      edge_d  = edge_q;
      sreg_d  = sreg_q;
      rxb_d   = rxb_q;
      ph_d    = ph_q;
      done_d  = 1'b0;
      unique case (state_q)
         SDL_IDLE: begin
            ph_d = 1'b0;
            if (x.start) begin
               sreg_d  = x.tx_data; // see [RULE_17]
               div_d   = 5'h01;
               edge_d  = 5'h00;
               state_d = SDL_SHIFT;
            end
         end
         SDL_SHIFT: begin
            if (div_q == half) begin
               div_d  = 5'h01;
               ph_d   = ~ph_q;
               edge_d = edge_q + 5'h01;
               if (!ph_q) begin
                  // Leading edge: sample in phase 0, shift in phase 1
                  if (!x.clock_phase)
                     rxb_d = miso_i;
                  else if (edge_q != 5'h00)
                     sreg_d = {sreg_q[6:0], rxb_q};
               end else begin
                  if (!x.clock_phase)
                     sreg_d = {sreg_q[6:0], rxb_q};
                  else
                     rxb_d = miso_i;
               end
               if (edge_q == `SDL_EDGES - 5'h01)
                  state_d = SDL_FINISH;
            end else begin
               div_d = div_q + 5'h01;
            end
         end
         SDL_FINISH: begin
            // Phase 1 still owes the last shift after the final edge
            if (x.clock_phase)
               sreg_d = {sreg_q[6:0], rxb_q};
            done_d  = 1'b1;
            state_d = SDL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= SDL_IDLE;
         div_q   <= 5'h00;
         edge_q  <= 5'h00;
         sreg_q  <= 8'h00;
         rxb_q   <= 1'b0;
         ph_q    <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         div_q   <= div_d;
         edge_q  <= edge_d;
         sreg_q  <= sreg_d;
         rxb_q   <= rxb_d;
         ph_q    <= ph_d;
         done_q  <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign sck_o     = x.clock_polarity ^ ph_q; // see [RULE_13]
   assign mosi_o    = sreg_q[7];     // see [RULE_17]
   assign x.busy    = (state_q != SDL_IDLE);
   assign x.done    = done_q;
   assign x.rx_data = sreg_q;
endmodule
`default_nettype wire

// *** sdl_checker.sv ***
// Port assertions for the DAC loader top level
`include "sdl_consts.svh"
`default_nettype none
module sdl_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq_o,
   input wire logic        sck_o,
   input wire logic        sck_oe_o,
   input wire logic        mosi_o,
   input wire logic        mosi_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctrl_q;
   logic [2:0] ev_en_q;
   logic       wr;
   logic       rd;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign rd = wb_ack_o && !wb_we_i;
   // Shadow of setup bits, so rules can be tied to the mode in force
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q  <= `SDL_CTRL_RESET;
         ev_en_q <= 3'h0;
      end else if (wr && wb_adr_i[7:2] == `SDL_IDX_CTRL) begin
         ctrl_q <= wb_dat_i[7:0];
      end else if (wr && wb_adr_i[7:2] == `SDL_IDX_EV_EN) begin
         ev_en_q <= wb_dat_i[2:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////
   a_ack_follows: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_stat_spare: assert property (
      rd && wb_adr_i[7:2] == `SDL_IDX_STAT |->
      wb_dat_o[31:8] == 24'h0 && !wb_dat_o[5] && wb_dat_o[3:0] == 4'h0)
      else $error("spare status bits not zero");
   a_ctrl_readback: assert property (
      rd && wb_adr_i[7:2] == `SDL_IDX_CTRL |-> wb_dat_o[7:0] == ctrl_q)
      else $error("control reads back wrong");
   a_rate_div16: assert property (
      ctrl_q[1:0] == 2'b10 && sck_oe_o && $changed(sck_o)
      |=> $stable(sck_o) [*7])
      else $error("serial clock half period not 8");
   a_rate_div4: assert property (
      ctrl_q[1:0] == 2'b01 && sck_oe_o && $changed(sck_o)
      |=> $stable(sck_o))
      else $error("serial clock half period not 2");
   a_pins_off: assert property (
      !ctrl_q[6] && !$past(ctrl_q[6]) |-> !sck_oe_o && !mosi_oe_o)
      else $error("pins driven while port disabled");
   a_irq_cause: assert property (irq_o |->
      ctrl_q[7] || $past(ctrl_q[7]) || ev_en_q != 3'h0
      || $past(ev_en_q) != 3'h0)
      else $error("interrupt without any enable");
   a_mosi_trail: assert property (
      ctrl_q[3:2] == 2'b00 && sck_oe_o && $changed(mosi_o)
      |-> !$rose(sck_o))
      else $error("data changed on the leading edge");
endmodule
bind sdl_top sdl_checker u_sdl_checker (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .irq_o(irq_o), .sck_o(sck_o),
   .sck_oe_o(sck_oe_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o));
`default_nettype wire

// *** sdl_dac_model.sv ***
// Serial DAC slave model: takes 16-bit words framed by chip select
`default_nettype none
module sdl_dac_model (
   input  wire logic        clk_i,
   input  wire logic        cs_n_i,
   input  wire logic        sck_i,
   input  wire logic        mosi_i,
   output logic             miso_o,
   output logic [15:0]      word_o,
   output logic [5:0]       nclk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sh = 16'h0000;
   logic [15:0] rb = 16'h0000;
   logic [5:0]  cnt = 6'h00;
   logic        tog = 1'b0;
   initial word_o = 16'h0000;
   initial nclk_o = 6'h00;
   // Slave only: never makes a clock, mode 0 sampling on rise
   always @(posedge sck_i) begin
      if (!cs_n_i) begin
         sh  <= {sh[14:0], mosi_i};
         cnt <= cnt + 6'h01;
      end
   end
   always @(negedge sck_i) begin
      if (!cs_n_i) rb <= {rb[14:0], 1'b0};
   end
   // Readback of the previous word, new frame restarts the count
   always @(negedge cs_n_i) begin
      rb  <= word_o;
      cnt <= 6'h00;
   end
   always @(posedge cs_n_i) begin
      word_o <= sh;
      nclk_o <= cnt;
   end
   // Released line shows a changing pattern, not a stale bit
   always @(posedge clk_i) tog <= ~tog;
   assign miso_o = cs_n_i ? tog : rb[15];
endmodule
`default_nettype wire

// *** sdl_top_tb.sv ***
// Self-checking bench for the DAC loader top level
`default_nettype none
module sdl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_i, cyc, stb, we, ack, irq, miso, sel_n, cs_n;
   logic        sck, sck_oe, mosi, mosi_oe, sck_w, mosi_w;
   logic [7:0]  adr, rdv;
   logic [31:0] dat, dat_o;
   logic [15:0] word, w, prev, e;
   logic [5:0]  nclk;
   logic [15:0] rdq[$];
   logic [15:0] dacq[$];
   int          errors, n_compared, seed, cyc_n;
   sdl_top u_sdl_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
      .sck_o(sck), .sck_oe_o(sck_oe), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
      .miso_i(miso), .sel_n_i(sel_n));
   // Pull-down on clock, pull-up on data when undriven
   assign sck_w = sck_oe ? sck : 1'b0;
   assign mosi_w = mosi_oe ? mosi : 1'b1;
   sdl_dac_model u_sdl_dac_model (.clk_i(clk_i), .cs_n_i(cs_n),
      .sck_i(sck_w), .mosi_i(mosi_w), .miso_o(miso), .word_o(word),
      .nclk_o(nclk));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] s,
                        input logic [15:0] x);
      n_compared++;
      if (s !== x) begin
         $display("wrong value %s expected %h seen %h", nm, x, s);
         errors++;
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= a;
      dat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rdv = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // Expected read noted as mask and value, mask zero means unchecked
   task automatic rd(input logic [7:0] a, m, v);
      rdq.push_back({m, v});
      wb(1'b0, a, 8'h00);
   endtask
   task automatic poll;
      rdv = 8'h00;
      while (rdv[7] !== 1'b1) rd(8'hA4, 8'h00, 8'h00);
   endtask
   task automatic send(input logic [15:0] v, input logic [7:0] m);
      cs_n <= 1'b0;
      wb(1'b1, 8'hA8, v[15:8]);
      poll();
      wb(1'b1, 8'hA8, v[7:0]);
      poll();
      rd(8'hA8, m, prev[7:0]);
      dacq.push_back(v);
      cs_n <= 1'b1;
   endtask
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && rdq.size() > 0) begin
         e = rdq.pop_front();
         if (e[15:8] != 8'h00) check("read", 16'(dat_o[7:0] & e[15:8]),
            16'(e[7:0]));
      end
   end
   always @(posedge cs_n) begin
      #1;
      if (dacq.size() > 0) begin
         check("dac word", word, dacq.pop_front());
         check("dac clocks", 16'(nclk), 16'h0010);
      end
   end
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 30000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      {rst_i, cs_n, sel_n} = 3'b111;
      {cyc, stb, we, adr, dat, prev} = '0;
      {errors, n_compared, cyc_n, seed} = {32'd0, 32'd0, 32'd0, 32'd76753};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'hA0, 8'hFC, 8'h04);
      rd(8'hA4, 8'hFF, 8'h00);
      rd(8'h80, 8'hFF, 8'h00);
      for (int r = 0; r < 4; r++) begin
         wb(1'b1, 8'hA0, 8'h50 | 8'(r));
         w = 16'($random(seed));
         send(w, r == 3 ? 8'hFF : 8'h00);
         prev = w;
         rd(8'hA4, 8'hFF, 8'h00);
      end
      // Mode 3 also shifts out on the falling edge, so the slave sees it
      wb(1'b1, 8'hA0, 8'h5D);
      w = 16'($random(seed));
      send(w, 8'h00);
      wb(1'b1, 8'hA0, 8'h53);
      // Second write lands while the first byte still shifts
      wb(1'b1, 8'hA8, 8'h3C);
      wb(1'b1, 8'hA8, 8'hC3);
      poll();
      rd(8'hA4, 8'hFF, 8'hC0);
      rd(8'hA8, 8'h00, 8'h00);
      rd(8'hA4, 8'hFF, 8'h00);
      wb(1'b1, 8'hA0, 8'hD3);
      sel_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      sel_n <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("irq", 16'(irq), 16'h0001);
      rd(8'hA4, 8'hFF, 8'h10);
      rd(8'hA8, 8'h00, 8'h00);
      rd(8'hA4, 8'hFF, 8'h10);
      wb(1'b1, 8'hA0, 8'h53);
      rd(8'hA4, 8'hFF, 8'h00);
      wb(1'b1, 8'hB4, 8'h07);
      wb(1'b1, 8'hB8, 8'h01);
      check("irq", 16'(irq), 16'h0000);
      wb(1'b1, 8'hA8, 8'h5A);
      poll();
      check("irq", 16'(irq), 16'h0001);
      wb(1'b1, 8'hB8, 8'h00);
      check("irq", 16'(irq), 16'h0000);
      rd(8'hB0, 8'h07, 8'h01);
      wb(1'b1, 8'hB8, 8'h01);
      wb(1'b1, 8'hB4, 8'h01);
      check("irq", 16'(irq), 16'h0000);
      wb(1'b1, 8'hA0, 8'h5B);
      check("sck idle", 16'(sck), 16'h0001);
      wb(1'b1, 8'hA0, 8'h13);
      check("pins", 16'({sck_oe, mosi_oe}), 16'h0000);
      print_verdict();
   end
endmodule
`default_nettype wire
